// >>> phy_mgmt_ctrl_status_regs.sv
`timescale 1ns/1ps
// What this block does
// RULE1: Fault flag latches; clears on read, AN edges
// RULE2: Resolution bit: 1 master, 0 slave
// RULE3: Local and remote receiver bits read zero
// RULE4: Partner gigabit duplex abilities in bits 11:10
// RULE5: Eight-bit idle error counter, clears on read
// RULE6: Function field selects address or data modes
// RULE7: Five-bit unit selector picks MMD 1/3/7
// RULE8: Window is address in mode 00, else data
// RULE9: Host writes address first, then data function
// RULE10: Extended status gigabit bits read zero
// RULE11: Crossover field resets auto, four encodings
// RULE12: Crossover applies only after software reset
// RULE13: CRS on transmit only when bit 3 set
// RULE14: SQE test off in full duplex
// RULE15: Polarity reversal on by default; off forces normal; code forces normal only in 10M, reversal stays on otherwise
// RULE16: Jabber only in 10M; bit 0 disables
module phy_mgmt_ctrl_status_regs
  import phy_mgmt_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  // Status from the link engine (same clock)
  input wire logic MS_FAULT_EVENT,
  input wire logic MS_RESOLVED_MASTER,
  input wire logic LP_GIG_HALF,
  input wire logic LP_GIG_FULL,
  input wire logic IDLE_ERROR,
  input wire logic AN_ENABLE,
  input wire logic AN_COMPLETE,
  input wire logic SOFT_RESET,
  // Link mode from the data path
  input wire logic FULL_DUPLEX,
  input wire logic MODE_10M,
  input wire logic TX_ACTIVE,
  input wire logic RX_ACTIVE,
  // MMD access port
  output logic [4:0] MMD_UNIT,
  output logic [15:0] MMD_ADDR,
  output logic [15:0] MMD_WDATA,
  output logic MMD_WR,
  output logic MMD_RD,
  input wire logic [15:0] MMD_RDATA,
  // Controls to the data path
  output logic [1:0] XOVER_MODE,
  output logic CRS,
  output logic SQE_TEST_EN,
  output logic POL_REVERSAL_EN,
  output logic JABBER_EN,
  // Interrupt
  output logic IRQ
);
  import phy_mgmt_pkg::*;

  logic ms_fault; // Latched fault flag
  logic [7:0] idle_count; // Idle error counter
  logic [1:0] mmd_func; // Function field
  logic [4:0] mmd_unit_select; // Unit selector
  logic [15:0] mmd_addr; // Stored MMD register address
  logic [1:0] crossover_select; // Software view of crossover
  logic [1:0] xover_active; // Applied crossover mode
  logic crs_on_tx; // CRS on transmit enable
  logic sqe_en; // SQE test request
  logic pol_en; // Polarity reversal enable
  logic jab_dis; // Jabber disable
  logic [IRQ_WIDTH-1:0] irq_status; // Sticky events
  logic [IRQ_WIDTH-1:0] irq_mask; // Interrupt enables
  logic an_enable_d; // Delayed AN enable for edge
  logic an_complete_d; // Delayed AN complete for edge
  logic rd_ms; // Read of master/slave status
  logic wr_window; // Write to window
  logic rd_window; // Read of window
  logic data_mode; // Window carries data
  logic inc_on_rd; // Post increment after read
  logic inc_on_wr; // Post increment after write
  logic [15:0] next_rdata; // Read mux result

  // Address match helper used by every decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction : hit

  assign rd_ms = RD && hit(ADDR, ADDR_MS_STATUS);
  assign wr_window = WR && hit(ADDR, ADDR_MMD_WINDOW);
  assign rd_window = RD && hit(ADDR, ADDR_MMD_WINDOW);
  // Any non-address function makes the window a data port
  assign data_mode = (mmd_func != MMD_ADDRESS); // [RULE8]
  assign inc_on_rd = (mmd_func == MMD_DATA_INC_RW); // [RULE6]
  assign inc_on_wr = (mmd_func == MMD_DATA_INC_RW)
    || (mmd_func == MMD_DATA_INC_WR); // [RULE6]

  // Edge history for the fault clear conditions
  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
    begin
      an_enable_d <= 1'b0;
      an_complete_d <= 1'b0;
    end
    else
    begin
      an_enable_d <= AN_ENABLE;
      an_complete_d <= AN_COMPLETE;
    end
  end

  // Fault flag; a new fault wins over any clear
  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
      ms_fault <= 1'b0;
    else if (MS_FAULT_EVENT)
      ms_fault <= 1'b1; // [RULE1]
    else if (rd_ms || (AN_ENABLE && !an_enable_d)
             || (AN_COMPLETE && !an_complete_d))
      ms_fault <= 1'b0; // [RULE1]
  end

  // Idle error counter, saturates, cleared by reading it
  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
      idle_count <= 8'h00; // [RULE5]
    else if (rd_ms)
      idle_count <= IDLE_ERROR ? 8'h01 : 8'h00; // [RULE5]
    else if (IDLE_ERROR && idle_count != 8'hff)
      idle_count <= idle_count + 8'h01; // [RULE5]
  end

  // MMD access control register
  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
    begin
      mmd_func <= MMD_ADDRESS;
      mmd_unit_select <= 5'h00;
    end
    else if (WR && hit(ADDR, ADDR_MMD_CTRL))
    begin
      mmd_func <= WDATA[FUNC_MSB:FUNC_LSB]; // [RULE6]
      mmd_unit_select <= WDATA[UNIT_MSB:0]; // [RULE7]
    end
  end

  // Stored MMD address; window writes land here in address mode
  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
      mmd_addr <= 16'h0000;
    else if (wr_window && !data_mode)
      mmd_addr <= WDATA; // [RULE8]
    else if ((wr_window && inc_on_wr) || (rd_window && inc_on_rd))
      mmd_addr <= mmd_addr + 16'h0001; // [RULE6]
  end

  // Strobes forwarded to the selected MMD in data mode
  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
    begin
      MMD_WR <= 1'b0;
      MMD_WDATA <= 16'h0000;
    end
    else
    begin
      MMD_WR <= wr_window && data_mode; // [RULE8]
      if (wr_window && data_mode)
        MMD_WDATA <= WDATA;
    end
  end

  // Read strobe is combinational so data is back next cycle
  assign MMD_RD = rd_window && data_mode; // [RULE8]
  assign MMD_ADDR = mmd_addr;
  // Unsupported selector codes are passed on; MMD decides
  assign MMD_UNIT = mmd_unit_select; // [RULE7]

  // Function control register
  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
    begin
      crossover_select <= XOVER_RESET; // [RULE11]
      crs_on_tx <= 1'b0;
      sqe_en <= 1'b0;
      pol_en <= 1'b1; // [RULE15]
      jab_dis <= 1'b0; // [RULE16]
    end
    else if (WR && hit(ADDR, ADDR_FUNC_CTRL))
    begin
      crossover_select <= WDATA[XOVER_MSB:XOVER_LSB]; // [RULE11]
      crs_on_tx <= WDATA[CRS_TX_BIT];
      sqe_en <= WDATA[SQE_BIT];
      pol_en <= WDATA[POL_BIT];
      jab_dis <= WDATA[JAB_BIT];
    end
  end

  // Applied crossover follows the field only on software reset
  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
      xover_active <= XOVER_RESET;
    else if (SOFT_RESET)
      xover_active <= crossover_select; // [RULE12]
  end

  // Data path controls, registered
  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
    begin
      CRS <= 1'b0;
      SQE_TEST_EN <= 1'b0;
      POL_REVERSAL_EN <= 1'b1;
      JABBER_EN <= 1'b0;
    end
    else
    begin
      // Full-duplex 10M never raises CRS on transmit
      CRS <= RX_ACTIVE || (TX_ACTIVE && crs_on_tx
             && !(MODE_10M && FULL_DUPLEX)); // [RULE13]
      SQE_TEST_EN <= sqe_en && !FULL_DUPLEX; // [RULE14]
      // Outside 10M polarity handling is not gated here
      POL_REVERSAL_EN <= pol_en || !MODE_10M; // [RULE15]
      JABBER_EN <= MODE_10M && !jab_dis; // [RULE16]
    end
  end
  assign XOVER_MODE = xover_active;

  // Interrupt status; set wins over write-one-to-clear
  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
      irq_status <= '0;
    else
    begin
      for (int i = 0; i < IRQ_WIDTH; i++)
      begin
        if ((i == IRQ_FAULT && MS_FAULT_EVENT)
            || (i == IRQ_IDLE_ERR && IDLE_ERROR))
          irq_status[i] <= 1'b1;
        else if (WR && hit(ADDR, ADDR_IRQ_STATUS) && WDATA[i])
          irq_status[i] <= 1'b0;
      end
    end
  end

  // Interrupt mask
  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
      irq_mask <= '0;
    else if (WR && hit(ADDR, ADDR_IRQ_MASK))
      irq_mask <= WDATA[IRQ_WIDTH-1:0];
  end
  assign IRQ = |(irq_status & irq_mask);

  // Read mux
  always_comb
  begin
    next_rdata = 16'h0000;
    unique case (1'b1)
      hit(ADDR, ADDR_MS_STATUS):
      begin
        next_rdata[MS_FAULT_BIT] = ms_fault; // [RULE1]
        next_rdata[MS_RES_BIT] = MS_RESOLVED_MASTER; // [RULE2]
        next_rdata[MS_LRX_BIT] = 1'b0; // [RULE3]
        next_rdata[MS_RRX_BIT] = 1'b0; // [RULE3]
        next_rdata[MS_LP_HD_BIT] = LP_GIG_HALF; // [RULE4]
        next_rdata[MS_LP_FD_BIT] = LP_GIG_FULL; // [RULE4]
        next_rdata[IDLE_CNT_MSB:0] = idle_count; // [RULE5]
      end
      hit(ADDR, ADDR_MMD_CTRL):
      begin
        next_rdata[FUNC_MSB:FUNC_LSB] = mmd_func;
        next_rdata[UNIT_MSB:0] = mmd_unit_select;
      end
      hit(ADDR, ADDR_EXT_STATUS):
        next_rdata = EXT_STATUS_VALUE; // [RULE10]
      hit(ADDR, ADDR_FUNC_CTRL):
      begin
        next_rdata[XOVER_MSB:XOVER_LSB] = crossover_select;
        next_rdata[CRS_TX_BIT] = crs_on_tx;
        next_rdata[SQE_BIT] = sqe_en;
        next_rdata[POL_BIT] = pol_en;
        next_rdata[JAB_BIT] = jab_dis;
      end
      hit(ADDR, ADDR_IRQ_STATUS):
        next_rdata[IRQ_WIDTH-1:0] = irq_status;
      hit(ADDR, ADDR_IRQ_MASK):
        next_rdata[IRQ_WIDTH-1:0] = irq_mask;
      default:
        next_rdata = 16'h0000;
    endcase
  end

  // Read data register; window data comes straight from the MMD
  // The MMD answers in the strobe cycle, so its data is caught here
  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
      RDATA <= 16'h0000;
    else if (rd_window && data_mode)
      RDATA <= MMD_RDATA; // [RULE8]
    else if (rd_window)
      RDATA <= mmd_addr; // [RULE8]
    else if (RD)
      RDATA <= next_rdata;
  end
endmodule : phy_mgmt_ctrl_status_regs

// >>> phy_mgmt_pkg.sv
package phy_mgmt_pkg;
  // Register offsets (word index on the plain port)
  localparam logic [7:0] ADDR_MS_STATUS = 8'h0a;
  localparam logic [7:0] ADDR_MMD_CTRL = 8'h0d;
  localparam logic [7:0] ADDR_MMD_WINDOW = 8'h0e;
  localparam logic [7:0] ADDR_EXT_STATUS = 8'h0f;
  localparam logic [7:0] ADDR_FUNC_CTRL = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h21;
  // Master/slave status fields
  localparam int MS_FAULT_BIT = 15;
  localparam int MS_RES_BIT = 14;
  localparam int MS_LRX_BIT = 13;
  localparam int MS_RRX_BIT = 12;
  localparam int MS_LP_HD_BIT = 11;
  localparam int MS_LP_FD_BIT = 10;
  localparam int IDLE_CNT_MSB = 7;
  // MMD control fields
  localparam int FUNC_MSB = 15;
  localparam int FUNC_LSB = 14;
  localparam int UNIT_MSB = 4;
  // Function control fields and reset
  localparam int XOVER_MSB = 6;
  localparam int XOVER_LSB = 5;
  localparam int CRS_TX_BIT = 3;
  localparam int SQE_BIT = 2;
  localparam int POL_BIT = 1;
  localparam int JAB_BIT = 0;
  localparam logic [1:0] XOVER_RESET = 2'h3;
  localparam logic [15:0] EXT_STATUS_VALUE = 16'h0080;
  // Interrupt bits
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_IDLE_ERR = 1;
  localparam int IRQ_WIDTH = 2;
  // MMD function codes
  typedef enum logic [1:0]
  {
    MMD_ADDRESS = 2'h0,
    MMD_DATA = 2'h1,
    MMD_DATA_INC_RW = 2'h2,
    MMD_DATA_INC_WR = 2'h3
  } mmd_func_t;
  // Crossover modes
  typedef enum logic [1:0]
  {
    XOVER_MDI = 2'h0,
    XOVER_MDIX = 2'h1,
    XOVER_RSVD = 2'h2,
    XOVER_AUTO = 2'h3
  } xover_t;
  // MMD unit selectors
  localparam logic [4:0] UNIT_MMD1 = 5'h01;
  localparam logic [4:0] UNIT_MMD3 = 5'h03;
  localparam logic [4:0] UNIT_MMD7 = 5'h07;
endpackage : phy_mgmt_pkg

// >>> phy_mgmt_checker.sv
`timescale 1ns/1ps
module phy_mgmt_checker
  import phy_mgmt_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  // Status and mode inputs
  input wire logic MS_FAULT_EVENT,
  input wire logic MS_RESOLVED_MASTER,
  input wire logic LP_GIG_HALF,
  input wire logic LP_GIG_FULL,
  input wire logic IDLE_ERROR,
  input wire logic SOFT_RESET,
  input wire logic FULL_DUPLEX,
  input wire logic MODE_10M,
  // Watched outputs
  input wire logic [15:0] MMD_WDATA,
  input wire logic MMD_WR,
  input wire logic MMD_RD,
  input wire logic [1:0] XOVER_MODE,
  input wire logic SQE_TEST_EN,
  input wire logic POL_REVERSAL_EN,
  input wire logic JABBER_EN
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RSTN);
  // Status read with no event landing in the same cycle
  sequence ms_rd;
    RD && ADDR == ADDR_MS_STATUS && !MS_FAULT_EVENT && !IDLE_ERROR;
  endsequence
  // Quiet gap between two reads, so nothing can set again
  sequence quiet;
    !MS_FAULT_EVENT && !IDLE_ERROR;
  endsequence
  a_fault_rd_clear: assert property (
    ms_rd ##1 quiet ##1 ms_rd |=> RDATA[15] == 1'b0 && RDATA[7:0] == 8'h00)
    else $error("fault or idle count not cleared by read");
  a_rx_bits_zero: assert property (
    RD && ADDR == ADDR_MS_STATUS |=> RDATA[13:12] == 2'b00)
    else $error("receiver status bits not zero");
  a_res_lp_bits: assert property (
    RD && ADDR == ADDR_MS_STATUS
    && $stable({MS_RESOLVED_MASTER, LP_GIG_HALF, LP_GIG_FULL})
    |=> RDATA[14] == $past(MS_RESOLVED_MASTER)
    && RDATA[11:10] == {$past(LP_GIG_HALF), $past(LP_GIG_FULL)})
    else $error("role or partner gigabit bits wrong");
  a_ext_status: assert property (
    RD && ADDR == ADDR_EXT_STATUS |=> RDATA == EXT_STATUS_VALUE)
    else $error("extended status value wrong");
  a_mmd_wr_src: assert property (
    MMD_WR |-> $past(WR && ADDR == ADDR_MMD_WINDOW)
    && MMD_WDATA == $past(WDATA))
    else $error("unit write without window write");
  a_mmd_rd_src: assert property (
    MMD_RD |-> RD && ADDR == ADDR_MMD_WINDOW)
    else $error("unit read without window read");
  a_xover_soft: assert property (
    $changed(XOVER_MODE) |-> $past(SOFT_RESET))
    else $error("crossover changed without soft reset");
  a_sqe_full_dup: assert property (
    FULL_DUPLEX && $past(FULL_DUPLEX) |-> !SQE_TEST_EN)
    else $error("signal quality test on in full duplex");
  a_non10_forces: assert property (
    !MODE_10M && !$past(MODE_10M) |-> POL_REVERSAL_EN && !JABBER_EN)
    else $error("polarity or jabber wrong outside 10M");
endmodule : phy_mgmt_checker

bind phy_mgmt_ctrl_status_regs phy_mgmt_checker chk_u (.*);

// >>> mgmt_host.sv
`timescale 1ns/1ps
// Station manager: one-cycle strobes, changed only after an edge
module mgmt_host
(
  // Clock
  input wire logic CLK_SYS,
  // Register port
  output logic [7:0] ADDR,
  output logic [15:0] WDATA,
  output logic WR,
  output logic RD
);
  // Idle bus from time zero
  initial
  begin
    ADDR = 8'h00;
    WDATA = 16'h0000;
    WR = 1'b0;
    RD = 1'b0;
  end
  // Write; the slave never stalls, so one edge completes it
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge CLK_SYS);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLK_SYS);
    WR <= 1'b0;
    WDATA <= ~v;
  endtask : wr
  // Read; data is taken by the bench one cycle later
  task automatic rd(input logic [7:0] a);
    @(posedge CLK_SYS);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK_SYS);
    RD <= 1'b0;
  endtask : rd
endmodule : mgmt_host

// >>> phy_mgmt_ctrl_status_regs_tb.sv
`timescale 1ns/1ps
module phy_mgmt_ctrl_status_regs_tb;
  import phy_mgmt_pkg::*;
  // Design pins, same names as the ports
  logic CLK_SYS = 1'b0;
  logic RSTN = 1'b0;
  logic MS_FAULT_EVENT, MS_RESOLVED_MASTER, LP_GIG_HALF, LP_GIG_FULL;
  logic IDLE_ERROR, AN_ENABLE, AN_COMPLETE, SOFT_RESET, FULL_DUPLEX;
  logic MODE_10M, TX_ACTIVE, RX_ACTIVE, WR, RD, MMD_WR, MMD_RD;
  logic CRS, SQE_TEST_EN, POL_REVERSAL_EN, JABBER_EN, IRQ;
  logic [7:0] ADDR;
  logic [15:0] WDATA, RDATA, MMD_ADDR, MMD_WDATA, MMD_RDATA;
  logic [4:0] MMD_UNIT;
  logic [1:0] XOVER_MODE;
  // Expected read data; bit 16 marks a checked read
  logic [16:0] exp_q[$];
  logic [16:0] e;
  logic [15:0] ea, d;
  logic rd_d = 1'b0;
  int errors = 0;
  int tests_run = 0;
  int seed = 62;
  logic [4:0] un [3] = '{UNIT_MMD1, UNIT_MMD3, UNIT_MMD7};
  logic [7:0] ra [7] = '{8'h0a, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h20, 8'h33};
  logic [15:0] rv [7] = '{16'h0000, 16'h0000, 16'h0000, 16'h0080,
    16'h0062, 16'h0000, 16'h0000};
  // Unit model answers a read with the inverse of its last write
  assign MMD_RDATA = ~MMD_WDATA;
  phy_mgmt_ctrl_status_regs dut_u (.*);
  mgmt_host host_u (.*);
  // Free-running system clock
  initial
  begin
    forever #2.5 CLK_SYS = ~CLK_SYS;
  end
  // Compare and count
  task automatic chk(input string n, input logic [15:0] x,
    input logic [15:0] g);
    tests_run++;
    if (g !== x)
    begin
      errors++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  // Note the expectation, then read
  task automatic rd(input logic [7:0] a, input logic [15:0] x,
    input logic c);
    exp_q.push_back({c, x});
    host_u.rd(a);
  endtask : rd
  // Verdict
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  // Read data stands one cycle after the strobe edge
  always @(posedge CLK_SYS)
  begin
    rd_d <= RD;
    if (rd_d && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      if (e[16])
        chk("RDATA", e[15:0], RDATA);
    end
  end
  // Hang guard
  initial
  begin
    #100us;
    errors++;
    report_and_stop();
  end
  // Main sequence
  initial
  begin
    {MS_FAULT_EVENT, MS_RESOLVED_MASTER, LP_GIG_HALF, LP_GIG_FULL,
      IDLE_ERROR, AN_ENABLE, AN_COMPLETE, SOFT_RESET, FULL_DUPLEX,
      MODE_10M, TX_ACTIVE, RX_ACTIVE} = '0;
    repeat (12) @(posedge CLK_SYS);
    RSTN <= 1'b1;
    for (int i = 0; i < 7; i++)
      rd(ra[i], rv[i], 1'b1);
    $display("test reset values done");
    @(posedge CLK_SYS);
    {MS_FAULT_EVENT, MS_RESOLVED_MASTER, LP_GIG_HALF, IDLE_ERROR} <= '1;
    repeat (3) @(posedge CLK_SYS);
    {MS_FAULT_EVENT, IDLE_ERROR} <= '0;
    rd(ADDR_IRQ_STATUS, 16'h0003, 1'b1);
    chk("IRQ", 16'h0000, 16'(IRQ));
    host_u.wr(ADDR_IRQ_MASK, 16'h0001);
    @(posedge CLK_SYS);
    chk("IRQ", 16'h0001, 16'(IRQ));
    host_u.wr(ADDR_IRQ_STATUS, 16'h0001);
    @(posedge CLK_SYS);
    chk("IRQ", 16'h0000, 16'(IRQ));
    rd(ADDR_MS_STATUS, 16'hc803, 1'b1);
    rd(ADDR_MS_STATUS, 16'h4800, 1'b1);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge CLK_SYS);
      MS_FAULT_EVENT <= 1'b1;
      @(posedge CLK_SYS);
      MS_FAULT_EVENT <= 1'b0;
      AN_ENABLE <= 1'b1;
      AN_COMPLETE <= (k == 1);
      @(posedge CLK_SYS);
      rd(ADDR_MS_STATUS, 16'h4800, 1'b1);
    end
    $display("test status and interrupt done");
    host_u.wr(ADDR_MMD_CTRL, {2'h0, 9'h000, UNIT_MMD7});
    ea = 16'($random(seed));
    host_u.wr(ADDR_MMD_WINDOW, ea);
    rd(ADDR_MMD_WINDOW, ea, 1'b1);
    for (int f = 1; f < 4; f++)
    begin
      d = 16'($random(seed));
      host_u.wr(ADDR_MMD_CTRL, {2'(f), 9'h000, un[f-1]});
      host_u.wr(ADDR_MMD_WINDOW, d);
      repeat (2) @(posedge CLK_SYS);
      ea = ea + 16'(f > 1);
      chk("MMD_WDATA", d, MMD_WDATA);
      chk("MMD_ADDR", ea, MMD_ADDR);
      chk("MMD_UNIT", 16'(un[f-1]), 16'(MMD_UNIT));
      rd(ADDR_MMD_WINDOW, ~d, 1'b1);
      repeat (2) @(posedge CLK_SYS);
      ea = ea + 16'(f == 2);
      chk("MMD_ADDR", ea, MMD_ADDR);
    end
    $display("test unit access done");
    host_u.wr(ADDR_FUNC_CTRL, 16'h000f);
    rd(ADDR_FUNC_CTRL, 16'h000f, 1'b1);
    chk("XOVER_MODE", 16'(XOVER_AUTO), 16'(XOVER_MODE));
    SOFT_RESET <= 1'b1;
    TX_ACTIVE <= 1'b1;
    @(posedge CLK_SYS);
    SOFT_RESET <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    chk("XOVER_MODE", 16'(XOVER_MDI), 16'(XOVER_MODE));
    chk("CTRL", 16'h000e, 16'({CRS, SQE_TEST_EN, POL_REVERSAL_EN,
      JABBER_EN}));
    FULL_DUPLEX <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    chk("CTRL", 16'h000a, 16'({CRS, SQE_TEST_EN, POL_REVERSAL_EN,
      JABBER_EN}));
    FULL_DUPLEX <= 1'b0;
    MODE_10M <= 1'b1;
    host_u.wr(ADDR_FUNC_CTRL, 16'h0000);
    repeat (2) @(posedge CLK_SYS);
    chk("CTRL", 16'h0001, 16'({CRS, SQE_TEST_EN, POL_REVERSAL_EN,
      JABBER_EN}));
    RX_ACTIVE <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    chk("CRS", 16'h0001, 16'(CRS));
    $display("test function control done");
    repeat (3) @(posedge CLK_SYS);
    report_and_stop();
  end
endmodule : phy_mgmt_ctrl_status_regs_tb
